// file: hdl/oprm_cfg.svh
// oprm_cfg.svh: offsets, field positions, reset values of the output remap block
// assumes: included by bare name from the package and the design files
`ifndef OPRM_CFG_SVH
`define OPRM_CFG_SVH

// bus geometry
`define OPRM_ADDR_W        12
`define OPRM_DATA_W        32

// register byte offsets, one aligned word each
`define OPRM_OFS_PINS_12_13 12'h000
`define OPRM_OFS_PINS_14_15 12'h004
`define OPRM_OFS_PINS_16_17 12'h008
`define OPRM_OFS_PINS_18_19 12'h00c

// number of selector registers and of remappable pins
`define OPRM_NUM_REGS      4
`define OPRM_NUM_PINS      8
// first register that is absent on the small package
`define OPRM_FIRST_OPT_REG 2

// field layout inside a 16-bit register
`define OPRM_SEL_W         5
`define OPRM_LO_SEL_LSB    0
`define OPRM_HI_SEL_LSB    8

// reset value of every selector
`define OPRM_SEL_RESET     5'h00
// selector code that connects nothing
`define OPRM_SEL_NONE      5'h00

// default count of peripheral output lines
`define OPRM_NUM_PERIPH    32

// bus response codes
`define OPRM_RESP_OKAY     2'h0
`define OPRM_RESP_SLVERR   2'h2

`endif

// file: hdl/oprm_pkg.sv
// oprm_pkg.sv: types of the output remap block
// assumes: oprm_cfg.svh is on the include path
`include "oprm_cfg.svh"

package oprm_pkg;

  // one selector value
  typedef logic [`OPRM_SEL_W-1:0] oprm_sel_t;

  // register file and bus slave state of the top module
  typedef struct packed {
    oprm_sel_t [`OPRM_NUM_PINS-1:0] sel;     // one selector per pin
    logic                           aw_got;  // write address held
    logic [`OPRM_ADDR_W-1:0]        aw_addr; // held write address
    logic                           w_got;   // write data held
    logic [15:0]                    w_data;  // held write data, low half
    logic [1:0]                     w_strb;  // held strobes, low lanes
    logic                           awready;
    logic                           wready;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           arready;
    logic                           rvalid;
    logic [`OPRM_DATA_W-1:0]        rdata;
    logic [1:0]                     rresp;
  } oprm_state_s;

  // state of one pin mux
  typedef struct packed {
    logic pin_out;  // driven pin level
    logic remap_en; // peripheral owns the pin
  } oprm_mux_s;

endpackage : oprm_pkg

// file: hdl/oprm_pin_mux.sv
// oprm_pin_mux.sv: routes one chosen peripheral output to one remappable pin
// assumes: peripheral outputs come from logic on aclk; selector from the register file
`timescale 1ns/1ps
`include "oprm_cfg.svh"

module oprm_pin_mux
  import oprm_pkg::*;
#(
  parameter int NUM_PERIPH = `OPRM_NUM_PERIPH
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`OPRM_SEL_W-1:0] selector,
  input  wire logic [NUM_PERIPH-1:0] periph_out,
  output      logic                  pin_out,
  output      logic                  remap_en
);

  oprm_mux_s mux_reg;  // registered pin state
  oprm_mux_s mux_next; // next pin state

  // pick the peripheral line numbered by the selector
  always_comb begin
    mux_next = '0;
    if (selector != `OPRM_SEL_NONE && 32'(selector) < NUM_PERIPH) begin // RL3
      mux_next.remap_en = 1'b1;
      mux_next.pin_out  = periph_out[selector]; // RL3
    end else begin
      // code zero or unknown line: port logic keeps the pin
      mux_next.remap_en = 1'b0; // RL11
      mux_next.pin_out  = 1'b0;
    end
  end

  // register the pin state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_reg <= '0;
    end else begin
      mux_reg <= mux_next;
    end
  end

  assign pin_out  = mux_reg.pin_out;
  assign remap_en = mux_reg.remap_en;

endmodule : oprm_pin_mux

// file: hdl/oprm_out_remap.sv
// oprm_out_remap.sv: output selector registers for remappable pins 12 to 19
// Notes on behaviour
// RL1: register one, bits 12:8 select pin 13
// RL2: register one, bits 4:0 select pin 12
// RL3: selector value n routes peripheral output n
// RL4: bits 15:13 and 7:5 read zero
// RL5: selector bits read/write, cleared on reset
// RL6: register two selects pins 15 and 14
// RL7: register three selects pins 17 and 16
// RL8: register four selects pins 19 and 18
// RL9: small package: registers three, four absent
// RL10: writes to unimplemented bits are dropped
// RL11: selector zero connects nothing, port keeps pin
//
// assumes: AXI4-Lite master on aclk; peripheral outputs on aclk;
// pin drivers downstream combine pin_out with remap_en.
`timescale 1ns/1ps
`include "oprm_cfg.svh"

module oprm_out_remap
  import oprm_pkg::*;
#(
  parameter int NUM_PERIPH    = `OPRM_NUM_PERIPH, // peripheral output lines
  parameter bit SMALL_PACKAGE = 1'b0              // 28-pin variant
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // write address channel
  input  wire logic [`OPRM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output      logic                    s_axi_awready,
  // write data channel
  input  wire logic [`OPRM_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output      logic                    s_axi_wready,
  // write response channel
  output      logic [1:0]              s_axi_bresp,
  output      logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // read address channel
  input  wire logic [`OPRM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output      logic                    s_axi_arready,
  // read data channel
  output      logic [`OPRM_DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]              s_axi_rresp,
  output      logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // peripheral output lines, line 0 unused
  input  wire logic [NUM_PERIPH-1:0]   periph_out,
  // remappable pins 12 to 19, bit 0 is pin 12
  output      logic [`OPRM_NUM_PINS-1:0] pin_out,
  output      logic [`OPRM_NUM_PINS-1:0] pin_remap_en
);

  oprm_state_s st_reg;  // all registered state
  oprm_state_s st_next; // next state

  // decode a byte address to a register index; returns mapped flag
  function automatic logic addr_hit(input logic [`OPRM_ADDR_W-1:0] addr,
                                    output logic [1:0]             idx);
    logic hit;
    hit = 1'b1;
    idx = 2'h0;
    unique case (addr)
      `OPRM_OFS_PINS_12_13: idx = 2'h0; // RL1 RL2
      `OPRM_OFS_PINS_14_15: idx = 2'h1; // RL6
      `OPRM_OFS_PINS_16_17: idx = 2'h2; // RL7
      `OPRM_OFS_PINS_18_19: idx = 2'h3; // RL8
      default:              hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_hit

  // a register is present unless the small package drops it
  function automatic logic reg_present(input logic [1:0] idx);
    return !(SMALL_PACKAGE && 32'(idx) >= `OPRM_FIRST_OPT_REG); // RL9
  endfunction : reg_present

  // read value of one register: two fields, gaps as zero
  function automatic logic [`OPRM_DATA_W-1:0] reg_value(
      input oprm_sel_t [`OPRM_NUM_PINS-1:0] sel,
      input logic [1:0]                     idx);
    logic [`OPRM_DATA_W-1:0] v;
    v = '0; // RL4
    if (reg_present(idx)) begin
      v[`OPRM_LO_SEL_LSB +: `OPRM_SEL_W] = sel[{idx, 1'b0}]; // RL2
      v[`OPRM_HI_SEL_LSB +: `OPRM_SEL_W] = sel[{idx, 1'b1}]; // RL1
    end
    return v;
  endfunction : reg_value

  // local helpers of the combinational process
  logic                    aw_fire;   // address taken this edge
  logic                    w_fire;    // data taken this edge
  logic                    do_write;  // both halves present
  logic [`OPRM_ADDR_W-1:0] wr_addr;   // address of the write
  logic [15:0]             wr_data;   // data of the write
  logic [1:0]              wr_strb;   // lane strobes of the write
  logic [1:0]              wr_idx;    // register index written
  logic                    wr_hit;    // write address mapped
  logic [1:0]              rd_idx;    // register index read
  logic                    rd_hit;    // read address mapped

  // next-state logic: register file and bus slave
  always_comb begin
    st_next  = st_reg;
    wr_idx   = 2'h0;
    rd_idx   = 2'h0;
    wr_hit   = 1'b0;
    rd_hit   = 1'b0;
    aw_fire  = s_axi_awvalid && st_reg.awready;
    w_fire   = s_axi_wvalid && st_reg.wready;

    // a finished response frees the write path
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // hold an address that arrives alone
    if (aw_fire) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end

    // hold data that arrives alone; only the low lanes matter
    if (w_fire) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata[15:0];
      st_next.w_strb = s_axi_wstrb[1:0];
    end

    // pick each half from the hold register or the bus
    wr_addr  = st_reg.aw_got ? st_reg.aw_addr : s_axi_awaddr;
    wr_data  = st_reg.w_got ? st_reg.w_data : s_axi_wdata[15:0];
    wr_strb  = st_reg.w_got ? st_reg.w_strb : s_axi_wstrb[1:0];
    do_write = (st_reg.aw_got || aw_fire) && (st_reg.w_got || w_fire);

    // perform the write once both halves are in
    if (do_write) begin
      wr_hit         = addr_hit(wr_addr, wr_idx);
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_hit ? `OPRM_RESP_OKAY : `OPRM_RESP_SLVERR;
      if (wr_hit && reg_present(wr_idx)) begin // RL9
        // lane 0 holds the low selector, bits 7:5 dropped
        if (wr_strb[0]) begin
          st_next.sel[{wr_idx, 1'b0}] =
            wr_data[`OPRM_LO_SEL_LSB +: `OPRM_SEL_W]; // RL2 RL5 RL10
        end
        // lane 1 holds the high selector, bits 15:13 dropped
        if (wr_strb[1]) begin
          st_next.sel[{wr_idx, 1'b1}] =
            wr_data[`OPRM_HI_SEL_LSB +: `OPRM_SEL_W]; // RL1 RL5 RL10
        end
      end
    end

    // a read response leaves once accepted
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // take a read and capture its data in the same edge
    if (s_axi_arvalid && st_reg.arready) begin
      rd_hit         = addr_hit(s_axi_araddr, rd_idx);
      st_next.rvalid = 1'b1;
      st_next.rresp  = rd_hit ? `OPRM_RESP_OKAY : `OPRM_RESP_SLVERR;
      st_next.rdata  = rd_hit ? reg_value(st_reg.sel, rd_idx) : '0; // RL4 RL9
    end

    // readies follow from the next state, so they leave a flop
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready  = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  // register all state; selectors clear on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg         <= '0;
      st_reg.sel     <= {`OPRM_NUM_PINS{`OPRM_SEL_RESET}}; // RL5
      st_reg.bresp   <= `OPRM_RESP_OKAY;
      st_reg.rresp   <= `OPRM_RESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // bus outputs straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // one mux per remappable pin, pin 12 + k on lane k
  for (genvar k = 0; k < `OPRM_NUM_PINS; k++) begin : g_pin
    oprm_pin_mux #(
      .NUM_PERIPH (NUM_PERIPH)
    ) u_mux (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .selector   (st_reg.sel[k]),     // RL3 RL6 RL7 RL8
      .periph_out (periph_out),
      .pin_out    (pin_out[k]),
      .remap_en   (pin_remap_en[k])    // RL11
    );
  end

  // protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:16], s_axi_wstrb[3:2]};

endmodule : oprm_out_remap

// file: test/oprm_out_remap_props.sv
// oprm_out_remap_props.sv: port assertions for the output remap registers
// assumes: bound to every oprm_out_remap instance, one aclk domain
`timescale 1ns/1ps
`include "oprm_cfg.svh"
module oprm_props (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [`OPRM_DATA_W-1:0]    s_axi_rdata,
  input wire logic [`OPRM_NUM_PINS-1:0]  pin_remap_en
);
  // all checks on the bus clock, quiet in reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_rd_zero_bits: assert property (s_axi_rvalid |-> s_axi_rdata[31:13] == 0 && s_axi_rdata[7:5] == 0)
    else $error("unused read bits set");
  a_rd_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_wr_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_rd_ready_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_pin_on_write: assert property ($changed(pin_remap_en) |-> $past(s_axi_bvalid))
    else $error("pin enable moved without a write");
  a_reset_clear: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_arready && pin_remap_en == 0)
    else $error("state not cleared by reset");
  // main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pin_on: cover property (pin_remap_en != 0);
endmodule : oprm_props

bind oprm_out_remap oprm_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .pin_remap_en);

// file: test/tb_oprm_out_remap.sv
// tb_oprm_out_remap.sv: self-checking bench for the output remap registers
// assumes: oprm_cfg.svh on the include path, design files compiled first
`timescale 1ns/1ps
`include "oprm_cfg.svh"
module tb_oprm_out_remap;
  typedef struct packed {
    logic [1:0]  resp; // expected response
    logic [31:0] d;    // expected word, full package
    logic [31:0] ds;   // expected word, small package
  } oprm_exp_s;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, periph_out = 0;
  logic [3:0]  s_axi_wstrb = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rdata_s;
  logic [7:0]  pin_out, pin_remap_en, pin_en_s;
  logic [15:0] m [4] = '{default: 0}; // register model
  oprm_exp_s   rq[$];                 // expected reads
  oprm_exp_s   ex;                    // oldest read note
  logic [1:0]  wq[$];                 // expected write responses
  int          err_total = 0, tests_run = 0, i, k, seed;
  logic [31:0] d;
  logic [3:0]  s;
  logic [4:0]  sel;
  always #2 aclk = ~aclk;
  oprm_out_remap dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_out,
    .pin_out, .pin_remap_en);
  // 28-pin variant on the same bus, answers in step with dut
  oprm_out_remap #(.SMALL_PACKAGE(1'b1)) dut_small (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(rdata_s),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .periph_out, .pin_out(),
    .pin_remap_en(pin_en_s));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic final_report;
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // one write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                    input logic [1:0] rs);
    @(posedge aclk);
    wq.push_back(rs);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= wd;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_bready);
  endtask : wr
  // one read, expectation noted first
  task automatic rd(input logic [11:0] a, input logic [1:0] rs, input logic [31:0] e, es);
    @(posedge aclk);
    rq.push_back(oprm_exp_s'{rs, e, es});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_rready);
  endtask : rd
  // monitor: oldest note against each answer
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      ex = rq.pop_front();
      check(s_axi_rdata, ex.d);
      check(rdata_s, ex.ds);
      check(32'(s_axi_rresp), 32'(ex.resp));
    end
    if (aresetn && s_axi_bvalid && s_axi_bready) check(32'(s_axi_bresp), 32'(wq.pop_front()));
  end
  // watchdog, far beyond the expected run
  initial begin
    #40000;
    err_total++;
    final_report;
  end
  initial begin
    seed = $urandom(32'h834e);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i++) rd(12'(i * 4), `OPRM_RESP_OKAY, 0, 0);
    // random words and strobes into random registers, each followed by a read of a random register
    repeat (40) begin
      i = $urandom_range(3);
      d = $urandom;
      s = 4'($urandom);
      periph_out <= $urandom;
      wr(12'(i * 4), d, s, `OPRM_RESP_OKAY);
      if (s[0]) m[i][4:0] = d[4:0];
      if (s[1]) m[i][12:8] = d[12:8];
      i = $urandom_range(3);
      rd(12'(i * 4), `OPRM_RESP_OKAY, {16'h0, m[i]}, i < 2 ? {16'h0, m[i]} : 32'h0);
    end
    // unmapped place refused
    wr(12'h010, 32'hffff_ffff, 4'hf, `OPRM_RESP_SLVERR);
    rd(12'h010, `OPRM_RESP_SLVERR, 0, 0);
    // pin 12 disconnected, pin 13 on line 0x15
    wr(`OPRM_OFS_PINS_12_13, 32'h0000_1500, 4'h3, `OPRM_RESP_OKAY);
    m[0] = 16'h1500;
    repeat (4) begin
      periph_out <= $urandom;
      repeat (3) @(posedge aclk);
      for (k = 0; k < 8; k++) begin
        sel = m[k / 2][(k % 2) * 8 +: 5];
        check(32'(pin_remap_en[k]), 32'(sel != 0));
        if (sel != 0) check(32'(pin_out[k]), 32'(periph_out[sel]));
      end
      check(32'(pin_en_s[7:4]), 32'h0);
    end
    final_report;
  end
endmodule : tb_oprm_out_remap
